// File: logic/twpi_irq.sv
`default_nettype none
`include "twpi_consts.svh"
//
// Operation
// - Reset clears hidden trap pending flag
// - Trap sets trap pending flag
// - Only clear op or reset clears it
// - Trap flag has no software access
// - Fetched opcode zero raises trap
// - Unused program memory fetches read zero
// - Stack pop past limit raises trap
// - Trap keeps enable, blocks maskables, steers vector
// - Only another trap interrupts trap routine
// - Trap acknowledged at once, top priority
// - Opcode trap return address is the trap opcode; pop trap keeps the old one
// - Clearing already clear flag does nothing
// - Eight wake pins share one vector
// - Per-pin enable gates each wake pin
// - Per-pin edge select rising or falling
// - Per-pin pending latch, no group flag
// - Wake request needs group, global, pending
// - Wake resumes or serves routine first
// - Maskables never nest, trap may preempt
// - Vector low byte even E0 to FE
// - Trap vector at top of table
module twpi_irq #(
   parameter bit LARGE_RAM = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pm_data,
   input wire logic pm_in_range,
   input wire logic fetch_strobe,
   input wire logic [14:0] fetch_addr,
   output logic [7:0] instr_byte,
   output logic [14:0] trap_return_addr,
   input wire logic stack_pop,
   input wire logic [7:0] stack_ptr_next,
   input wire logic clear_trap_pending_op,
   input wire logic vector_select_op,
   input wire logic irq_taken,
   input wire logic return_from_irq_op,
   input wire logic [12:0] other_req,
   input wire logic low_power,
   input wire logic [7:0] wake_pins,
   output logic trap_req,
   output logic irq_req,
   output logic [7:0] vector_low,
   output logic wake_up,
   output logic wake_to_isr
);
   ////////////////////////////////////////////////////////////////
   // Declarations
   twpi_arb_if arb (); // Link to vector arbiter
   logic [7:0] wake_pin_irq_enable_r; // Per-pin enable
   logic [7:0] wake_pin_edge_select_r; // One selects falling
   logic [7:0] wake_pin_pending; // Latched edges
   logic [7:0] wake_hit; // Edge seen this cycle
   logic [7:0] pend_clr; // Write one to clear
   logic wake_port_group_enable_r; // Group enable
   logic global_irq_enable_r; // Global enable
   logic trap_pending_flag_r; // Hidden trap flag
   logic trap_pending_flag_nxt; // Next trap flag
   logic in_service_r; // Maskable routine running
   logic in_service_nxt; // Next service state
   logic gie_nxt; // Next global enable
   logic irq_req_nxt; // Next maskable request
   logic [7:0] instr_r; // Loaded instruction
   logic [14:0] ret_addr_r; // Trap return address
   logic trap_req_r; // Trap pulse to core
   logic irq_req_r; // Maskable request to core
   logic [7:0] vector_r; // Selected vector byte
   logic wake_up_r; // Wake pulse
   logic wake_isr_r; // Wake serves routine
   logic [31:0] prdata_r; // Read data
   logic pready_r; // Access answer
   logic pslverr_r; // Unmapped access
   // APB phase and address decode, ahead of every use
   wire apb_setup = psel & ~penable;
   wire apb_wr = psel & penable & pwrite & pready_r;
   wire apb_wr_ctrl = apb_wr && paddr == `TWPI_OFF_CTRL;
   wire hit_en = paddr == `TWPI_OFF_WAKE_EN;
   wire hit_edge = paddr == `TWPI_OFF_WAKE_EDGE;
   wire hit_pend = paddr == `TWPI_OFF_WAKE_PEND;
   wire hit_ctrl = paddr == `TWPI_OFF_CTRL;
   wire hit_stat = paddr == `TWPI_OFF_STATUS;
   wire apb_hit = hit_en | hit_edge | hit_pend | hit_ctrl | hit_stat;
   ////////////////////////////////////////////////////////////////
   // Fetch path and trap detection
   // Out-of-range fetch reads as zero
   wire [7:0] fetched_byte = pm_in_range ? pm_data : `TWPI_ZERO_BYTE;
   // Zero opcode on the byte being fetched
   wire opcode_trap = fetch_strobe & (fetched_byte == `TWPI_TRAP_OPCODE);
   // Stack limit by RAM size
   wire [7:0] stack_limit = LARGE_RAM ? `TWPI_STACK_LIMIT_LARGE : `TWPI_STACK_LIMIT_SMALL;
   // Pop beyond the limit
   wire pop_trap = stack_pop & (stack_ptr_next > stack_limit);
   wire trap_hit = opcode_trap | pop_trap;
   ////////////////////////////////////////////////////////////////
   // Hidden trap flag, set wins over clear
   assign trap_pending_flag_nxt = trap_hit
      | (trap_pending_flag_r & ~clear_trap_pending_op);
   // Flag has no bus path at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_pending_flag_r <= 1'b0;
      end else begin
         trap_pending_flag_r <= trap_pending_flag_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Instruction and return address capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_r <= `TWPI_ZERO_BYTE;
         ret_addr_r <= 15'h0000;
      end else begin
         if (fetch_strobe) begin
            instr_r <= fetched_byte;
         end
         // Address of the trap opcode itself
         if (opcode_trap) begin
            ret_addr_r <= fetch_addr;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // Wake port pins
   assign pend_clr = (apb_wr && paddr == `TWPI_OFF_WAKE_PEND) ? pwdata[7:0] : `TWPI_ZERO_BYTE;
   genvar g;
   generate
      for (g = 0; g < `TWPI_WAKE_PINS; g++) begin : g_pin
         // One edge latch per pin
         twpi_wake_pin u_pin (
            .pclk(pclk),
            .presetn(presetn),
            .pin(wake_pins[g]),
            .edge_fall(wake_pin_edge_select_r[g]),
            .clr(pend_clr[g]),
            .hit(wake_hit[g]),
            .pend(wake_pin_pending[g])
         );
      end
   endgenerate
   // Enabled pending pins, gated by group enable
   wire wake_any = |(wake_pin_pending & wake_pin_irq_enable_r);
   wire wake_req = wake_port_group_enable_r & wake_any;
   ////////////////////////////////////////////////////////////////
   // Vector arbitration
   assign arb.trap_pending = trap_pending_flag_r;
   assign arb.req = {other_req, wake_req, 1'b0};
   twpi_arbiter u_arb (
      .bus(arb)
   );
   // A maskable slot was chosen by this select
   wire vis_maskable = vector_select_op & ~trap_pending_flag_r
      & (arb.slot != `TWPI_SLOT_DEFAULT);
   ////////////////////////////////////////////////////////////////
   // Service state and global enable
   // Maskable routine runs until its return
   assign in_service_nxt = vis_maskable | (in_service_r & ~return_from_irq_op);
   // Entry clears, return sets, trap leaves it alone
   assign gie_nxt = apb_wr_ctrl ? pwdata[`TWPI_CTRL_GIE_BIT]
      : return_from_irq_op ? 1'b1
      : irq_taken ? 1'b0
      : global_irq_enable_r;
   // No maskable while trap or routine active
   assign irq_req_nxt = global_irq_enable_r & ~in_service_r & ~trap_pending_flag_r
      & ~trap_hit & (wake_req | (|other_req));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_service_r <= 1'b0;
         global_irq_enable_r <= 1'b0;
         irq_req_r <= 1'b0;
         trap_req_r <= 1'b0;
      end else begin
         in_service_r <= in_service_nxt;
         global_irq_enable_r <= gie_nxt;
         irq_req_r <= irq_req_nxt;
         trap_req_r <= trap_hit;
      end
   end
   // Latch vector on select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vector_r <= `TWPI_VEC_BASE;
      end else if (vector_select_op) begin
         vector_r <= arb.vector;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Wake from halt or idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_up_r <= 1'b0;
         wake_isr_r <= 1'b0;
      end else begin
         // Enabled edge while in low power
         wake_up_r <= low_power & (|(wake_hit & wake_pin_irq_enable_r));
         // Serve routine only with interrupt on
         wake_isr_r <= wake_port_group_enable_r & global_irq_enable_r;
      end
   end
   ////////////////////////////////////////////////////////////////
   // APB slave
   wire [31:0] ctrl_word = {30'h0000_0000, global_irq_enable_r, wake_port_group_enable_r};
   wire [31:0] stat_word = {30'h0000_0000, irq_req_r, in_service_r};
   // Read mux, unmapped reads zero
   wire [31:0] rd_word = hit_en ? {24'h00_0000, wake_pin_irq_enable_r}
      : hit_edge ? {24'h00_0000, wake_pin_edge_select_r}
      : hit_pend ? {24'h00_0000, wake_pin_pending}
      : hit_ctrl ? ctrl_word
      : hit_stat ? stat_word
      : `TWPI_ZERO_WORD;
   // Answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= `TWPI_ZERO_WORD;
      end else begin
         pready_r <= apb_setup;
         pslverr_r <= apb_setup & ~apb_hit;
         if (apb_setup) begin
            prdata_r <= pwrite ? `TWPI_ZERO_WORD : rd_word;
         end
      end
   end
   // Software writable wake and group settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_pin_irq_enable_r <= `TWPI_ZERO_BYTE;
         wake_pin_edge_select_r <= `TWPI_ZERO_BYTE;
         wake_port_group_enable_r <= 1'b0;
      end else begin
         if (apb_wr && hit_en) begin
            wake_pin_irq_enable_r <= pwdata[7:0];
         end
         if (apb_wr && hit_edge) begin
            wake_pin_edge_select_r <= pwdata[7:0];
         end
         if (apb_wr_ctrl) begin
            wake_port_group_enable_r <= pwdata[`TWPI_CTRL_GRP_BIT];
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign instr_byte = instr_r;
   assign trap_return_addr = ret_addr_r;
   assign trap_req = trap_req_r;
   assign irq_req = irq_req_r;
   assign vector_low = vector_r;
   assign wake_up = wake_up_r;
   assign wake_to_isr = wake_isr_r;
   ////////////////////////////////////////////////////////////////
   // Assertions
   a_trap_sets: assert property (@(posedge pclk) disable iff (!presetn)
      trap_hit |=> trap_pending_flag_r) else $error("trap did not set flag");
   a_trap_clears: assert property (@(posedge pclk) disable iff (!presetn)
      clear_trap_pending_op && !trap_hit |=> !trap_pending_flag_r)
      else $error("clear op left flag set");
   a_trap_holds: assert property (@(posedge pclk) disable iff (!presetn)
      trap_pending_flag_r && !clear_trap_pending_op |=> trap_pending_flag_r)
      else $error("trap flag dropped without clear op");
   a_trap_vector: assert property (@(posedge pclk) disable iff (!presetn)
      vector_select_op && trap_pending_flag_r |=> vector_low == `TWPI_VEC_TRAP)
      else $error("trap vector not selected");
   a_vector_even: assert property (@(posedge pclk) disable iff (!presetn)
      vector_select_op |=> !vector_low[0] && vector_low >= `TWPI_VEC_BASE)
      else $error("vector byte out of table");
   a_mask_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      trap_pending_flag_r || in_service_r |=> !irq_req)
      else $error("maskable request during trap or routine");
   a_trap_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      trap_hit |=> trap_req ##1 (trap_req == $past(trap_hit)))
      else $error("trap not acknowledged at once");
   a_zero_fetch: assert property (@(posedge pclk) disable iff (!presetn)
      fetch_strobe && !pm_in_range |=> instr_byte == `TWPI_TRAP_OPCODE && trap_pending_flag_r)
      else $error("unused fetch did not trap");
   a_ret_addr: assert property (@(posedge pclk) disable iff (!presetn)
      opcode_trap |=> trap_return_addr == $past(fetch_addr))
      else $error("return address not trap opcode");
   a_wake_gated: assert property (@(posedge pclk) disable iff (!presetn)
      irq_req && other_req == 13'h0000 |-> $past(global_irq_enable_r))
      else $error("wake request without global enable");
   a_pend_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (wake_pin_pending & ~pend_clr) != 8'h00
      |=> (wake_pin_pending & $past(wake_pin_pending & ~pend_clr))
      == $past(wake_pin_pending & ~pend_clr))
      else $error("wake pending bit lost");
endmodule // twpi_irq
`default_nettype wire

// File: shared/twpi_consts.svh
`ifndef TWPI_CONSTS_SVH
`define TWPI_CONSTS_SVH
// Register byte offsets on the APB side
`define TWPI_OFF_WAKE_EN 8'h00
`define TWPI_OFF_WAKE_EDGE 8'h04
`define TWPI_OFF_WAKE_PEND 8'h08
`define TWPI_OFF_CTRL 8'h0c
`define TWPI_OFF_STATUS 8'h10
// Control register field positions
`define TWPI_CTRL_GRP_BIT 0
`define TWPI_CTRL_GIE_BIT 1
// Status register field positions
`define TWPI_STAT_SERV_BIT 0
`define TWPI_STAT_REQ_BIT 1
// Reset and fill values
`define TWPI_ZERO_BYTE 8'h00
`define TWPI_ZERO_WORD 32'h0000_0000
// Trap opcode and stack pop limits
`define TWPI_TRAP_OPCODE 8'h00
`define TWPI_STACK_LIMIT_SMALL 8'h2f
`define TWPI_STACK_LIMIT_LARGE 8'h6f
// Vector table low bytes and slots
`define TWPI_VEC_BASE 8'he0
`define TWPI_VEC_TRAP 8'hfe
`define TWPI_SLOT_TRAP 4'hf
`define TWPI_SLOT_DEFAULT 4'h0
`define TWPI_SLOT_WAKE 1
`define TWPI_SLOT_TOP 14
// Source counts
`define TWPI_WAKE_PINS 8
`define TWPI_OTHER_SRCS 13
`endif

// File: shared/twpi_pkg.sv
`default_nettype none
package twpi_pkg;
   // One data byte
   typedef logic [7:0] twpi_byte_type;
   // Arbitration slot, fifteen is the trap
   typedef logic [3:0] twpi_slot_type;
   // Maskable requests by slot, bit zero unused
   typedef logic [14:0] twpi_req_type;
endpackage
`default_nettype wire

// File: shared/twpi_arb_if.sv
`default_nettype none
interface twpi_arb_if;
   logic trap_pending; // Trap flag as seen by arbitration
   twpi_pkg::twpi_req_type req; // Maskable requests by slot
   twpi_pkg::twpi_byte_type vector; // Selected vector low byte
   twpi_pkg::twpi_slot_type slot; // Selected slot
   // Top drives requests, arbiter answers
   modport top (output trap_pending, output req, input vector, input slot);
   modport arb (input trap_pending, input req, output vector, output slot);
endinterface
`default_nettype wire

// File: logic/twpi_arbiter.sv
`default_nettype none
`include "twpi_consts.svh"
module twpi_arbiter (
   twpi_arb_if.arb bus
);
   twpi_pkg::twpi_slot_type pick; // Highest active slot
   ////////////////////////////////////////////////////////////////
   // Highest ranked request wins, trap above all
   always_comb begin
      pick = `TWPI_SLOT_DEFAULT;
      for (int i = 1; i <= `TWPI_SLOT_TOP; i++) begin
         if (bus.req[i]) begin
            pick = 4'(i);
         end
      end
      if (bus.trap_pending) begin
         pick = `TWPI_SLOT_TRAP;
      end
   end
   // Even low byte from base upward
   assign bus.slot = pick;
   assign bus.vector = `TWPI_VEC_BASE + {3'b000, pick, 1'b0};
endmodule // twpi_arbiter
`default_nettype wire

// File: logic/twpi_wake_pin.sv
`default_nettype none
`include "twpi_consts.svh"
module twpi_wake_pin (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   input wire logic edge_fall,
   input wire logic clr,
   output logic hit,
   output logic pend
);
   logic prev_r; // Last pin sample
   logic primed_r; // First sample taken
   logic pend_r; // Latched edge
   ////////////////////////////////////////////////////////////////
   // Selected edge seen between two samples
   assign hit = primed_r & (edge_fall ? (prev_r & ~pin) : (~prev_r & pin));
   assign pend = pend_r;
   // Sample pin, latch edge, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= 1'b0;
         primed_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         prev_r <= pin;
         primed_r <= 1'b1;
         pend_r <= hit | (pend_r & ~clr);
      end
   end
endmodule // twpi_wake_pin
`default_nettype wire

// File: test/twpi_pm_model.sv
`default_nettype none
/////////////////////////////////////////////////////////////////////////////
// Program store on the core side of the block
module twpi_pm_model #(
   parameter int MEM_BYTES = 1024
) (
   input wire logic [14:0] fetch_addr,
   output logic [7:0] pm_data,
   output logic pm_in_range
);
   timeunit 1ns;
   timeprecision 1ns;
   // Addresses below the store size exist
   assign pm_in_range = (32'(fetch_addr) < MEM_BYTES);
   // One zero opcode at 0x0010, other bytes odd
   // Beyond the store the bus floats: a pattern that follows the address
   assign pm_data = pm_in_range ?
      ((fetch_addr == 15'h0010) ? 8'h00 : (fetch_addr[7:0] | 8'h01)) :
      (fetch_addr[7:0] ^ 8'ha5);
endmodule // twpi_pm_model
`default_nettype wire

// File: test/trap_and_wake_port_irq_tb.sv
`default_nettype none
module trap_and_wake_port_irq_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int k; logic [14:0] v; logic t; logic [7:0] ins;} twpi_row_type;
   localparam int OP_F = 0; // Fetch
   localparam int OP_P = 1; // Stack pop
   localparam int OP_C = 2; // Clear trap flag
   localparam int OP_V = 3; // Vector select
   localparam int OP_R = 4; // Return from irq
   localparam int OP_I = 5; // Core enters an interrupt
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, pm_data, instr_byte, stack_ptr_next, wake_pins, vector_low;
   logic [31:0] pwdata, prdata, rd;
   logic pm_in_range, fetch_strobe, stack_pop, clear_trap_pending_op;
   logic vector_select_op, return_from_irq_op, low_power, irq_taken;
   logic trap_req, irq_req, wake_up, wake_to_isr;
   logic [14:0] fetch_addr, trap_return_addr;
   logic [12:0] other_req;
   int fails = 0;
   int checked = 0;
   // Fetch and pop cases: kind, value, trap expected, opcode expected
   twpi_row_type rows [7] = '{
      '{0, 15'h0003, 1'b0, 8'h03}, '{0, 15'h0010, 1'b1, 8'h00},
      '{0, 15'h03ff, 1'b0, 8'hff}, '{0, 15'h0400, 1'b1, 8'h00},
      '{0, 15'h7000, 1'b1, 8'h00}, '{1, 15'h002f, 1'b0, 8'h00},
      '{1, 15'h0030, 1'b1, 8'h00}};
   /////////////////////////////////////////////////////////////////////////
   twpi_irq #(.LARGE_RAM(1'b0)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pm_data(pm_data),
      .pm_in_range(pm_in_range), .fetch_strobe(fetch_strobe),
      .fetch_addr(fetch_addr), .instr_byte(instr_byte),
      .trap_return_addr(trap_return_addr), .stack_pop(stack_pop),
      .stack_ptr_next(stack_ptr_next),
      .clear_trap_pending_op(clear_trap_pending_op),
      .vector_select_op(vector_select_op), .irq_taken(irq_taken),
      .return_from_irq_op(return_from_irq_op), .other_req(other_req),
      .low_power(low_power), .wake_pins(wake_pins), .trap_req(trap_req),
      .irq_req(irq_req), .vector_low(vector_low), .wake_up(wake_up),
      .wake_to_isr(wake_to_isr));
   twpi_pm_model #(.MEM_BYTES(1024)) pm (
      .fetch_addr(fetch_addr), .pm_data(pm_data), .pm_in_range(pm_in_range));
   /////////////////////////////////////////////////////////////////////////
   // Clock, 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      fails++;
      close_out();
   end
   /////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One APB transfer; pready, read data and error taken at one rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Request held until pready is seen high at a rising edge
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         fails++;
         close_out();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One-cycle core pulse, returns just after the sampling edge
   task automatic pulse(input int k, input logic [14:0] v);
      @(posedge pclk);
      case (k)
         OP_F: begin
            fetch_strobe <= 1'b1;
            fetch_addr <= v;
         end
         OP_P: begin
            stack_pop <= 1'b1;
            stack_ptr_next <= v[7:0];
         end
         OP_C: clear_trap_pending_op <= 1'b1;
         OP_V: vector_select_op <= 1'b1;
         OP_I: irq_taken <= 1'b1;
         default: return_from_irq_op <= 1'b1;
      endcase
      @(posedge pclk);
      irq_taken <= 1'b0;
      fetch_strobe <= 1'b0;
      stack_pop <= 1'b0;
      clear_trap_pending_op <= 1'b0;
      vector_select_op <= 1'b0;
      return_from_irq_op <= 1'b0;
      #1;
   endtask
   task automatic idle(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   task automatic pins(input logic [7:0] v);
      @(posedge pclk);
      wake_pins <= v;
      idle(1);
   endtask
   /////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, fetch_strobe, stack_pop} = '0;
      {clear_trap_pending_op, vector_select_op, return_from_irq_op} = '0;
      {paddr, pwdata, fetch_addr, stack_ptr_next, other_req} = '0;
      {wake_pins, low_power, irq_taken} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      idle(1);
      chk(vector_low, 32'h0000_00e0);
      chk(trap_req, 1'b0);
      for (int a = 0; a < 5; a++) begin
         apb(1'b0, 8'(a * 4), 32'h0000_0000);
         chk(rd, 32'h0000_0000);
      end
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk({rd[30:0], err}, 32'h0000_0001);
      // Table of fetches and pops
      foreach (rows[i]) begin
         pulse(rows[i].k, rows[i].v);
         chk(trap_req, rows[i].t);
         if (rows[i].k == OP_F) chk(instr_byte, rows[i].ins);
         if (rows[i].t && rows[i].k == OP_F) chk(trap_return_addr, rows[i].v);
         pulse(OP_C, 15'h0000);
         chk(trap_req, 1'b0);
      end
      // Trap against a waiting maskable request
      apb(1'b1, 8'h0c, 32'h0000_0003);
      @(posedge pclk);
      other_req <= 13'h0001;
      idle(2);
      chk(irq_req, 1'b1);
      pulse(OP_F, 15'h0010);
      chk(trap_req, 1'b1);
      chk(irq_req, 1'b0);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      idle(2);
      chk(irq_req, 1'b0);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      pulse(OP_V, 15'h0000);
      chk(vector_low, 32'h0000_00fe);
      idle(2);
      chk(irq_req, 1'b0);
      pulse(OP_F, 15'h0010);
      chk(trap_req, 1'b1);
      pulse(OP_C, 15'h0000);
      pulse(OP_C, 15'h0000);
      idle(2);
      chk(irq_req, 1'b1);
      pulse(OP_V, 15'h0000);
      chk(vector_low, 32'h0000_00e4);
      idle(2);
      chk(irq_req, 1'b0);
      // Core entry drops the global enable, group enable stays
      pulse(OP_I, 15'h0000);
      apb(1'b0, 8'h0c, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      pulse(OP_F, 15'h0010);
      chk(trap_req, 1'b1);
      pulse(OP_C, 15'h0000);
      pulse(OP_R, 15'h0000);
      idle(2);
      chk(irq_req, 1'b1);
      @(posedge pclk);
      other_req <= 13'h0000;
      // Wake port: edges, sticky pending, gating
      apb(1'b1, 8'h0c, 32'h0000_0000);
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h0000_0006);
      pins(8'h03);
      pins(8'h01);
      pins(8'h05);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(rd, 32'h0000_0003);
      apb(1'b1, 8'h0c, 32'h0000_0001);
      idle(2);
      chk(irq_req, 1'b0);
      apb(1'b1, 8'h0c, 32'h0000_0003);
      idle(2);
      chk(irq_req, 1'b1);
      chk(wake_to_isr, 1'b1);
      pulse(OP_V, 15'h0000);
      chk(vector_low, 32'h0000_00e2);
      pulse(OP_R, 15'h0000);
      apb(1'b1, 8'h08, 32'h0000_0001);
      apb(1'b0, 8'h08, 32'h0000_0000);
      chk(rd, 32'h0000_0002);
      idle(2);
      chk(irq_req, 1'b0);
      apb(1'b1, 8'h0c, 32'h0000_0000);
      idle(2);
      chk(wake_to_isr, 1'b0);
      @(posedge pclk);
      low_power <= 1'b1;
      pins(8'h04);
      chk(wake_up, 1'b0);
      pins(8'h05);
      chk(wake_up, 1'b1);
      // Reset in mid-run with the trap flag set
      pulse(OP_F, 15'h0010);
      @(posedge pclk);
      presetn <= 1'b0;
      other_req <= 13'h0001;
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, 8'h0c, 32'h0000_0003);
      idle(2);
      chk(irq_req, 1'b1);
      close_out();
   end
endmodule // trap_and_wake_port_irq_tb
`default_nettype wire
